// ### design/ams_ctrl.sv
// Mode, auto-sleep/auto-wake and interrupt control with a two-wire register slave.
// Assumes SCL/SDA and the sample toggle are asynchronous; sample strobes are sparse.
// Contract
// [RULE1] Rate status bit 0 shows active rate in use, bit 1 wake rate; rest zero.
// [RULE2] Any write to the sleep limit register clears the sleep counter.
// [RULE3] Sleep counter reaching the limit leaves auto-sleep for the wake rate.
// [RULE4] Front/back change interrupts only when its enable is set.
// [RULE5] Orientation change interrupts only when its enable is set.
// [RULE6] Tap detection interrupts only when its enable is set.
// [RULE7] Leaving auto-sleep interrupts only when its enable is set.
// [RULE8] Every sample update interrupts when enabled; no effect on sleep or wake.
// [RULE9] Per-axis shake enables gate both interrupt and shake status bit.
// [RULE10] Interrupt holds until the address acknowledge of the next transaction.
// [RULE11] Mode register write restarts sleep timing, clears axes and tilt.
// [RULE12] Mode register read restarts sleep timing only.
// [RULE13] Host changes registers only in standby; other writes are refused. Code takes mode writes always, axes in test mode, others while active is clear.
// [RULE14] Mode decoded from active bit and test bit: standby, test, active.
// [RULE15] Host enters test mode only from standby.
// [RULE16] Host never sets active and test bits together.
// [RULE17] Active mode always starts at active rate, auto-sleep phase first.
// [RULE18] Test mode axes come from host writes and are processed as active.
// [RULE19] Test mode disables debounce filtering and shake detection.
// [RULE20] Auto-wake uses wake rate; a selected event returns to active rate.
// [RULE21] Auto-sleep uses active rate; timeout switches to wake rate.
// [RULE22] Sleep counter clock is sample rate divided by 1 or 16.
// [RULE23] Interrupt pin is open-drain or push-pull by the drive select bit.
// [RULE24] Interrupt pin is active low or high by the polarity bit.
// [RULE25] All enabled sources merge into one latched request on the pin.
`timescale 1ns/1ns

module ams_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         ce_in,
	// Asynchronous level in, filtered level out
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			q_out <= '0;
		end else if (ce_in) begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Only a level seen twice in a row counts, which rejects one-cycle glitches
			if (s2_q == s3_q) begin
				q_out <= s3_q;
			end
		end
	end
endmodule

module ams_ctrl #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
	// System
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  ce_in,
	// Two-wire register port
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe_out,
	// Interrupt pin
	output logic                       int_out,
	output logic                       int_oe_out,
	// Sample link from the front end
	input  wire logic                  clk_smp_in,
	input  wire logic                  smp_valid_in,
	input  wire ams_pkg::ams_sample_s  smp_in,
	// Front end control
	output logic                       wake_rate_out,
	output logic                       test_mode_out,
	output logic [7:0]                 rate_cfg_out,
	output ams_pkg::ams_axes_s         axes_out
);
	ams_pkg::ams_sample_s  smp_hold_q;
	logic                  smp_tog_q;
	logic                  tog_s;
	logic                  tog_seen_q;
	logic                  smp_evt;
	logic                  scl_f;
	logic                  sda_f;
	logic                  scl_d_q;
	logic                  sda_d_q;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  i2c_start;
	logic                  i2c_stop;
	ams_pkg::ams_i2c_e     st_q;
	ams_pkg::ams_i2c_e     nxt_q;
	logic [7:0]            sh_q;
	logic [3:0]            bits_q;
	logic [7:0]            ptr_q;
	logic [7:0]            rd_val;
	logic                  addr_ack;
	logic                  wr_pulse;
	logic                  rd_load;
	logic                  wr_mode;
	logic                  wr_limit;
	logic                  rd_mode;
	ams_pkg::ams_mode_s    mode_q;
	ams_pkg::ams_irq_en_s  irq_en_q;
	logic [7:0]            limit_q;
	logic [7:0]            rate_cfg_q;
	ams_pkg::ams_axes_s    axes_q;
	ams_pkg::ams_tilt_s    tilt_q;
	ams_pkg::ams_phase_e   phase_q;
	logic [3:0]            pre_q;
	logic [7:0]            cnt_q;
	logic                  irq_q;
	logic                  active_req;
	logic                  test_req;
	logic                  running;
	logic [2:0]            shake_hit;
	logic                  src_fb;
	logic                  src_pl;
	logic                  src_tap;
	logic                  src_shake;
	logic                  wake_evt;
	logic                  ctick;
	logic                  timeout;
	logic                  restart;
	logic                  pin_level;
	logic [7:0]            rate_status_v;

	// Link side: each sample is held until the next and announced by a toggle
	always_ff @(posedge clk_smp_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			smp_hold_q <= '0;
			smp_tog_q  <= 1'h0;
		end else if (smp_valid_in) begin
			smp_hold_q <= smp_in;
			smp_tog_q  <= ~smp_tog_q;
		end
	end

	ams_sync #(.W(1)) u_tog_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.d_in     (smp_tog_q),
		.q_out    (tog_s)
	);

	ams_sync #(.W(2)) u_pin_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.d_in     ({scl_in, sda_in}),
		.q_out    ({scl_f, sda_f})
	);

	// Held sample is stable long before its toggle is seen here
	assign smp_evt   = tog_s != tog_seen_q;
	assign scl_rise  = scl_f & ~scl_d_q;
	assign scl_fall  = ~scl_f & scl_d_q;
	assign i2c_start = scl_f & scl_d_q & sda_d_q & ~sda_f;
	assign i2c_stop  = scl_f & scl_d_q & ~sda_d_q & sda_f;
	assign addr_ack  = (st_q == ams_pkg::I2C_ADDR) & scl_fall & (bits_q == ams_pkg::BYTE_BITS)
		& (sh_q[7:1] == DEV_ADDR);
	assign wr_pulse  = (st_q == ams_pkg::I2C_WDATA) & scl_fall & (bits_q == ams_pkg::BYTE_BITS);
	assign rd_load   = scl_fall & (((st_q == ams_pkg::I2C_ACK) & (nxt_q == ams_pkg::I2C_RDATA))
		| (st_q == ams_pkg::I2C_RACK));
	assign wr_mode   = wr_pulse & (ptr_q == ams_pkg::ADDR_MODE);
	assign wr_limit  = wr_pulse & (ptr_q == ams_pkg::ADDR_SLEEP_LIMIT);
	assign rd_mode   = rd_load & (ptr_q == ams_pkg::ADDR_MODE);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tog_seen_q <= 1'h0;
			scl_d_q    <= 1'h0;
			sda_d_q    <= 1'h0;
			sda_out    <= 1'h0;
		end else if (ce_in) begin
			tog_seen_q <= tog_s;
			scl_d_q    <= scl_f;
			sda_d_q    <= sda_f;
			sda_out    <= 1'h0;
		end
	end

	// Two-wire slave: bytes shift on SCL rise, SDA changes after SCL fall
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q       <= ams_pkg::I2C_IDLE;
			nxt_q      <= ams_pkg::I2C_IDLE;
			sh_q       <= 8'h00;
			bits_q     <= 4'h0;
			ptr_q      <= 8'h00;
			sda_oe_out <= 1'h0;
		end else if (ce_in) begin
			if (i2c_start) begin
				st_q       <= ams_pkg::I2C_ADDR;
				bits_q     <= 4'h0;
				sda_oe_out <= 1'h0;
			end else if (i2c_stop) begin
				st_q       <= ams_pkg::I2C_IDLE;
				sda_oe_out <= 1'h0;
			end else begin
				case (st_q)
					ams_pkg::I2C_ADDR, ams_pkg::I2C_PTR, ams_pkg::I2C_WDATA: begin
						if (scl_rise && bits_q != ams_pkg::BYTE_BITS) begin
							sh_q   <= {sh_q[6:0], sda_f};
							bits_q <= bits_q + 4'h1;
						end else if (scl_fall && bits_q == ams_pkg::BYTE_BITS) begin
							bits_q     <= 4'h0;
							sda_oe_out <= 1'h1;
							st_q       <= ams_pkg::I2C_ACK;
							nxt_q      <= ams_pkg::I2C_WDATA;
							if (st_q == ams_pkg::I2C_ADDR) begin
								if (sh_q[7:1] != DEV_ADDR) begin
									sda_oe_out <= 1'h0;
									st_q       <= ams_pkg::I2C_IDLE;
								end else if (sh_q[0]) begin
									nxt_q <= ams_pkg::I2C_RDATA;
								end else begin
									nxt_q <= ams_pkg::I2C_PTR;
								end
							end else if (st_q == ams_pkg::I2C_PTR) begin
								ptr_q <= sh_q;
							end else begin
								ptr_q <= ptr_q + 8'h01;
							end
						end
					end
					ams_pkg::I2C_ACK, ams_pkg::I2C_RACK: begin
						if (st_q == ams_pkg::I2C_RACK && scl_rise && sda_f) begin
							st_q <= ams_pkg::I2C_IDLE;
						end else if (rd_load) begin
							sh_q       <= rd_val;
							sda_oe_out <= ~rd_val[7];
							bits_q     <= 4'h0;
							st_q       <= ams_pkg::I2C_RDATA;
						end else if (scl_fall) begin
							sda_oe_out <= 1'h0;
							st_q       <= nxt_q;
						end
					end
					ams_pkg::I2C_RDATA: begin
						if (scl_rise) begin
							bits_q <= bits_q + 4'h1;
						end else if (scl_fall && bits_q == ams_pkg::BYTE_BITS) begin
							sda_oe_out <= 1'h0;
							ptr_q      <= ptr_q + 8'h01;
							st_q       <= ams_pkg::I2C_RACK;
						end else if (scl_fall) begin
							sda_oe_out <= ~sh_q[6];
							sh_q       <= {sh_q[6:0], 1'h0};
						end
					end
					default: begin
						sda_oe_out <= 1'h0;
					end
				endcase
			end
		end
	end

	assign rate_status_v = {6'h00, phase_q == ams_pkg::PH_DOZE, phase_q == ams_pkg::PH_AWAKE}; // [RULE1]

	always_comb begin
		rd_val = 8'h00;
		if (ptr_q == ams_pkg::ADDR_X) begin
			rd_val = {2'h0, axes_q.x};
		end else if (ptr_q == ams_pkg::ADDR_Y) begin
			rd_val = {2'h0, axes_q.y};
		end else if (ptr_q == ams_pkg::ADDR_Z) begin
			rd_val = {2'h0, axes_q.z};
		end else if (ptr_q == ams_pkg::ADDR_TILT) begin
			rd_val = tilt_q;
		end else if (ptr_q == ams_pkg::ADDR_RATE_STATUS) begin
			rd_val = rate_status_v;
		end else if (ptr_q == ams_pkg::ADDR_SLEEP_LIMIT) begin
			rd_val = limit_q;
		end else if (ptr_q == ams_pkg::ADDR_INT_SETUP) begin
			rd_val = irq_en_q;
		end else if (ptr_q == ams_pkg::ADDR_MODE) begin
			rd_val = mode_q;
		end else if (ptr_q == ams_pkg::ADDR_RATE_CFG) begin
			rd_val = rate_cfg_q;
		end
	end

	// Mode register is always writable so the host can return to standby
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q     <= ams_pkg::MODE_RST;
			irq_en_q   <= ams_pkg::INT_SETUP_RST;
			limit_q    <= ams_pkg::SLEEP_LIMIT_RST;
			rate_cfg_q <= ams_pkg::RATE_CFG_RST;
		end else if (ce_in && wr_pulse) begin
			if (ptr_q == ams_pkg::ADDR_MODE) begin
				mode_q <= ams_pkg::ams_mode_s'(sh_q);
			end else if (!mode_q.active) begin // [RULE13]
				if (ptr_q == ams_pkg::ADDR_SLEEP_LIMIT) begin
					limit_q <= sh_q;
				end else if (ptr_q == ams_pkg::ADDR_INT_SETUP) begin
					irq_en_q <= ams_pkg::ams_irq_en_s'(sh_q);
				end else if (ptr_q == ams_pkg::ADDR_RATE_CFG) begin
					rate_cfg_q <= sh_q;
				end
			end
		end
	end

	assign active_req = mode_q.active & ~mode_q.test_on; // [RULE14]
	assign test_req   = mode_q.test_on & ~mode_q.active; // [RULE14]
	assign running    = phase_q != ams_pkg::PH_STANDBY;
	// Shake detection is off in test mode
	assign shake_hit  = smp_hold_q.shake & {irq_en_q.shake_x, irq_en_q.shake_y, irq_en_q.shake_z}
		& {3{phase_q != ams_pkg::PH_TEST}}; // [RULE9] [RULE19]
	assign src_fb     = smp_evt & running & irq_en_q.front_back
		& (smp_hold_q.bafro != tilt_q.bafro); // [RULE4]
	assign src_pl     = smp_evt & running & irq_en_q.orient
		& (smp_hold_q.pola != tilt_q.pola); // [RULE5]
	assign src_tap    = smp_evt & running & irq_en_q.tap & smp_hold_q.tap; // [RULE6]
	assign src_shake  = smp_evt & running & (|shake_hit); // [RULE9]
	// The every-sample source is kept out of the wake events on purpose
	assign wake_evt   = src_fb | src_pl | src_tap | src_shake; // [RULE8]
	assign ctick      = smp_evt & (~mode_q.prescale16 | (pre_q == ams_pkg::PRESCALE_LAST)); // [RULE22]
	assign timeout    = (phase_q == ams_pkg::PH_AWAKE) & active_req & mode_q.auto_sleep & ctick
		& (cnt_q == limit_q); // [RULE3]
	assign restart    = wr_limit | wr_mode | rd_mode | wake_evt; // [RULE2] [RULE11] [RULE12]

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_q <= ams_pkg::PH_STANDBY;
		end else if (ce_in) begin
			case (phase_q)
				ams_pkg::PH_AWAKE: begin
					if (!active_req) begin
						phase_q <= test_req ? ams_pkg::PH_TEST : ams_pkg::PH_STANDBY;
					end else if (timeout) begin
						phase_q <= ams_pkg::PH_DOZE; // [RULE21]
					end
				end
				ams_pkg::PH_DOZE: begin
					if (!active_req) begin
						phase_q <= test_req ? ams_pkg::PH_TEST : ams_pkg::PH_STANDBY;
					end else if (wr_mode || (mode_q.auto_wake && wake_evt)) begin
						phase_q <= ams_pkg::PH_AWAKE; // [RULE20]
					end
				end
				default: begin
					if (active_req) begin
						phase_q <= ams_pkg::PH_AWAKE; // [RULE17]
					end else if (test_req) begin
						phase_q <= ams_pkg::PH_TEST;
					end else begin
						phase_q <= ams_pkg::PH_STANDBY;
					end
				end
			endcase
		end
	end

	// Counts only while the active-rate phase runs; any other phase holds it at zero
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_q <= 4'h0;
			cnt_q <= 8'h00;
		end else if (ce_in) begin
			if (restart || phase_q != ams_pkg::PH_AWAKE) begin
				pre_q <= 4'h0; // [RULE2]
				cnt_q <= 8'h00; // [RULE11] [RULE12]
			end else if (smp_evt) begin
				pre_q <= pre_q + 4'h1; // [RULE22]
				if (ctick) begin
					cnt_q <= (cnt_q == limit_q) ? 8'h00 : cnt_q + 8'h01; // [RULE3]
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			axes_q <= '0;
			tilt_q <= '0;
		end else if (ce_in) begin
			if (wr_mode) begin
				axes_q <= '0; // [RULE11]
				tilt_q <= '0; // [RULE11]
			end else if (wr_pulse && test_req) begin
				if (ptr_q == ams_pkg::ADDR_X) begin
					axes_q.x <= sh_q[5:0]; // [RULE18]
				end else if (ptr_q == ams_pkg::ADDR_Y) begin
					axes_q.y <= sh_q[5:0]; // [RULE18]
				end else if (ptr_q == ams_pkg::ADDR_Z) begin
					axes_q.z <= sh_q[5:0]; // [RULE18]
				end
			end else if (smp_evt && running) begin
				if (phase_q != ams_pkg::PH_TEST) begin
					axes_q <= smp_hold_q.axes;
				end
				tilt_q <= {|shake_hit, 1'h0, smp_hold_q.tap, smp_hold_q.pola,
					smp_hold_q.bafro}; // [RULE9] [RULE18]
			end
		end
	end

	// A new event in the release cycle wins over the release
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_q <= 1'h0;
		end else if (ce_in) begin
			irq_q <= wake_evt | (timeout & irq_en_q.sleep_exit)
				| (smp_evt & running & irq_en_q.every_sample) | (irq_q & ~addr_ack); // [RULE7] [RULE8] [RULE10] [RULE25]
		end
	end

	assign pin_level = mode_q.pol_high ? irq_q : ~irq_q; // [RULE24]

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			int_out       <= 1'h1;
			int_oe_out    <= 1'h0;
			wake_rate_out <= 1'h0;
			test_mode_out <= 1'h0;
			rate_cfg_out  <= ams_pkg::RATE_CFG_RST;
			axes_out      <= '0;
		end else if (ce_in) begin
			int_out       <= pin_level; // [RULE24]
			int_oe_out    <= mode_q.push_pull | ~pin_level; // [RULE23]
			wake_rate_out <= phase_q == ams_pkg::PH_DOZE; // [RULE20] [RULE21]
			test_mode_out <= phase_q == ams_pkg::PH_TEST; // [RULE19]
			rate_cfg_out  <= rate_cfg_q;
			axes_out      <= axes_q; // [RULE18]
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	property p_rate_status;
		rate_status_v[7:2] == 6'h00 && !(rate_status_v[0] && rate_status_v[1]);
	endproperty
	a_rate_status: assert property (p_rate_status) else $error("rate status malformed"); // [RULE1]

	property p_limit_clear;
		ce_in && wr_limit |=> cnt_q == 8'h00;
	endproperty
	a_limit_clear: assert property (p_limit_clear) else $error("counter not cleared"); // [RULE2]

	property p_timeout;
		ce_in && timeout |=> phase_q == ams_pkg::PH_DOZE && rate_status_v == 8'h02;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not doze"); // [RULE3]

	property p_sleep_irq;
		ce_in && timeout && irq_en_q.sleep_exit |=> irq_q;
	endproperty
	a_sleep_irq: assert property (p_sleep_irq) else $error("sleep exit irq missing"); // [RULE7]

	property p_hold;
		ce_in && irq_q && !addr_ack |=> irq_q;
	endproperty
	a_hold: assert property (p_hold) else $error("irq dropped early"); // [RULE10]

	property p_mode_clear;
		ce_in && wr_mode |=> axes_q == '0 && tilt_q == '0 && cnt_q == 8'h00;
	endproperty
	a_mode_clear: assert property (p_mode_clear) else $error("mode write did not clear"); // [RULE11]

	property p_enter_active;
		ce_in && phase_q == ams_pkg::PH_STANDBY && active_req |=> phase_q == ams_pkg::PH_AWAKE;
	endproperty
	a_enter_active: assert property (p_enter_active) else $error("not at active rate"); // [RULE17]

	property p_test_shake;
		ce_in && smp_evt && phase_q == ams_pkg::PH_TEST |=> !tilt_q.shake;
	endproperty
	a_test_shake: assert property (p_test_shake) else $error("shake set in test"); // [RULE19]

	property p_prescale;
		ce_in && phase_q == ams_pkg::PH_AWAKE && !restart && mode_q.prescale16 && smp_evt
			&& pre_q != ams_pkg::PRESCALE_LAST |=> $stable(cnt_q);
	endproperty
	a_prescale: assert property (p_prescale) else $error("counter moved off prescale"); // [RULE22]

	property p_pin_level;
		ce_in |=> int_out == ($past(mode_q.pol_high) ? $past(irq_q) : !$past(irq_q));
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("pin polarity wrong"); // [RULE24]

	property p_open_drain;
		ce_in && !mode_q.push_pull |=> int_oe_out == !int_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drives high"); // [RULE23]

	c_timeout: cover property (ce_in && timeout);
	c_rewake: cover property (phase_q == ams_pkg::PH_DOZE ##1 phase_q == ams_pkg::PH_AWAKE);
	c_release: cover property (irq_q && addr_ack);
	c_test_wr: cover property (wr_pulse && test_req && ptr_q == ams_pkg::ADDR_X);
endmodule

// ### pkg/ams_pkg.sv
// Shared constants and types for the accelerometer mode, sleep and interrupt control block.
// Assumes a single system clock domain for registers and a separate sample clock at the link.
package ams_pkg;

	// Register offsets on the two-wire port
	localparam logic [7:0] ADDR_X           = 8'h00;
	localparam logic [7:0] ADDR_Y           = 8'h01;
	localparam logic [7:0] ADDR_Z           = 8'h02;
	localparam logic [7:0] ADDR_TILT        = 8'h03;
	localparam logic [7:0] ADDR_RATE_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SLEEP_LIMIT = 8'h05;
	localparam logic [7:0] ADDR_INT_SETUP   = 8'h06;
	localparam logic [7:0] ADDR_MODE        = 8'h07;
	localparam logic [7:0] ADDR_RATE_CFG    = 8'h08;

	// Values after reset
	localparam logic [7:0] SLEEP_LIMIT_RST  = 8'h00;
	localparam logic [7:0] INT_SETUP_RST    = 8'h00;
	localparam logic [7:0] MODE_RST         = 8'h00;
	localparam logic [7:0] RATE_CFG_RST     = 8'h00;

	// Rate status bit positions
	localparam int RATE_ACTIVE_BIT = 0;
	localparam int RATE_WAKE_BIT   = 1;

	// Sleep counter prescaler: divide by 16 ends on count 15
	localparam logic [3:0] PRESCALE_LAST = 4'hF;
	// Bits in one two-wire byte
	localparam logic [3:0] BYTE_BITS     = 4'h8;

	typedef struct packed {
		logic pol_high;
		logic push_pull;
		logic prescale16;
		logic auto_sleep;
		logic auto_wake;
		logic test_on;
		logic rsvd;
		logic active;
	} ams_mode_s;

	typedef struct packed {
		logic shake_x;
		logic shake_y;
		logic shake_z;
		logic every_sample;
		logic sleep_exit;
		logic tap;
		logic orient;
		logic front_back;
	} ams_irq_en_s;

	typedef struct packed {
		logic       shake;
		logic       alert;
		logic       tap;
		logic [2:0] pola;
		logic [1:0] bafro;
	} ams_tilt_s;

	typedef struct packed {
		logic [5:0] x;
		logic [5:0] y;
		logic [5:0] z;
	} ams_axes_s;

	// One sample from the front end; shake is ordered x, y, z
	typedef struct packed {
		ams_axes_s  axes;
		logic [1:0] bafro;
		logic [2:0] pola;
		logic       tap;
		logic [2:0] shake;
	} ams_sample_s;

	typedef enum logic [1:0] {PH_STANDBY, PH_TEST, PH_AWAKE, PH_DOZE} ams_phase_e;

	typedef enum logic [2:0] {
		I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_PTR, I2C_WDATA, I2C_RDATA, I2C_RACK
	} ams_i2c_e;

endpackage

// ### test/ams_i2c_host.sv
// Two-wire host model: drives SCL, pulls or releases SDA, reads the wired SDA level.
// Assumes the bench gives SDA a pull-up and folds in the device's pull-down.
`timescale 1ns/1ns
module ams_i2c_host (
	// Clock
	input  wire logic clk_in,
	// Pins
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_rel_out
);
	// Cycles per SCL half; a larger value acts as a slow host
	int half = 12;
	initial begin
		scl_out = 1'b1;
		sda_rel_out = 1'b1;
	end
	task automatic hw();
		repeat (half) @(posedge clk_in);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_rel_out = b;
		hw();
		scl_out = 1'b1;
		hw();
		r = sda_in;
		scl_out = 1'b0;
	endtask
	// Ninth bit released: device ACK on writes, host NACK on single reads
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(1'b1, a);
	endtask
	task automatic start();
		sda_rel_out = 1'b1;
		hw();
		scl_out = 1'b1;
		hw();
		sda_rel_out = 1'b0;
		hw();
		scl_out = 1'b0;
	endtask
	task automatic acc(input logic rd, input logic [7:0] p, d, output logic [7:0] q);
		logic [7:0] j;
		start();
		xfer(8'h54, j);
		xfer(p, j);
		q = 8'h00;
		if (rd) begin
			start();
			xfer(8'h55, j);
			xfer(8'hFF, q);
		end else begin
			xfer(d, j);
		end
		sda_rel_out = 1'b0;
		hw();
		scl_out = 1'b1;
		hw();
		sda_rel_out = 1'b1;
		hw();
	endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the mode, sleep and interrupt control block.
// Assumes the default bus address and a free-running sample clock.
`timescale 1ns/1ns
module tb_top;
	logic                 clk_sys_in = 1'b0;
	logic                 clk_smp    = 1'b0;
	logic                 rst_n_in   = 1'b0;
	logic                 smp_valid  = 1'b0;
	logic                 ce         = 1'b1;
	ams_pkg::ams_sample_s smp        = '0;
	logic                 scl, rel, sda_o, sda_oe, int_o, int_oe, wake, tmode;
	logic [7:0]           rcfg, rd;
	ams_pkg::ams_axes_s   axes;
	int                   n_errors   = 0;
	int                   compares   = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	initial begin
		#7;
		forever #16 clk_smp = ~clk_smp;
	end
	ams_i2c_host host (.clk_in(clk_sys_in), .sda_in(rel & ~sda_oe), .scl_out(scl),
		.sda_rel_out(rel));
	ams_ctrl dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce),
		.scl_in(scl), .sda_in(rel & ~sda_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.int_out(int_o), .int_oe_out(int_oe), .clk_smp_in(clk_smp),
		.smp_valid_in(smp_valid), .smp_in(smp), .wake_rate_out(wake),
		.test_mode_out(tmode), .rate_cfg_out(rcfg), .axes_out(axes));
	task automatic chk(input logic [17:0] s, e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] p, d);
		logic [7:0] j;
		host.acc(1'b0, p, d, j);
	endtask
	task automatic rdchk(input logic [7:0] p, e);
		host.acc(1'b1, p, 8'h00, rd);
		chk(18'(rd), 18'(e));
	endtask
	task automatic sample(input logic [2:0] pola, input logic tap);
		@(posedge clk_smp);
		#1;
		smp.pola = pola;
		smp.tap = tap;
		smp_valid = 1'b1;
		@(posedge clk_smp);
		#1;
		smp_valid = 1'b0;
		repeat (20) @(posedge clk_sys_in);
		#1;
	endtask
	// Sleep timeout after limit+1 samples, restarted by a limit write or a mode read
	task automatic t_sleep(input logic by_read);
		wr(8'h07, 8'h00);
		wr(8'h05, 8'h02);
		wr(8'h06, 8'h0A);
		wr(8'h07, 8'h19);
		rdchk(8'h04, 8'h01);
		repeat (2) sample(3'h0, 1'b0);
		if (by_read) rdchk(8'h07, 8'h19);
		else wr(8'h05, 8'h07);
		repeat (2) sample(3'h0, 1'b0);
		chk(18'(wake), 18'h0);
		sample(3'h0, 1'b0);
		chk(18'(wake), 18'h1);
		chk(18'({int_oe, int_o}), 18'h2);
		rdchk(8'h05, 8'h02);
		chk(18'(int_oe), 18'h0);
		rdchk(8'h04, 8'h02);
		sample(3'h1, 1'b0);
		chk(18'(wake), 18'h0);
		chk(18'(int_oe), 18'h1);
		rdchk(8'h04, 8'h01);
	endtask
	// A tap seen while the clock enable is low is only acted on once it returns
	task automatic t_irq();
		wr(8'h07, 8'h00);
		wr(8'h06, 8'h04);
		wr(8'h07, 8'hC1);
		chk(18'(tmode), 18'h0);
		sample(3'h0, 1'b0);
		chk(18'({int_oe, int_o}), 18'h2);
		ce = 1'b0;
		sample(3'h0, 1'b1);
		chk(18'({int_oe, int_o}), 18'h2);
		ce = 1'b1;
		repeat (20) @(posedge clk_sys_in);
		sample(3'h0, 1'b0);
		chk(18'({int_oe, int_o}), 18'h3);
		rdchk(8'h06, 8'h04);
		chk(18'(int_o), 18'h0);
		wr(8'h07, 8'h00);
		wr(8'h06, 8'h10);
		wr(8'h07, 8'hC1);
		sample(3'h0, 1'b0);
		chk(18'(int_o), 18'h1);
	endtask
	task automatic t_test();
		wr(8'h07, 8'h00);
		wr(8'h07, 8'h04);
		chk(18'(tmode), 18'h1);
		wr(8'h00, 8'h15);
		chk(18'(axes.x), 18'h15);
		wr(8'h07, 8'h00);
		chk(18'(axes), 18'h0);
		wr(8'h08, 8'h5A);
		chk(18'(rcfg), 18'h5A);
	endtask
	task automatic t_presc();
		wr(8'h05, 8'h00);
		wr(8'h07, 8'h31);
		repeat (15) sample(3'h0, 1'b0);
		chk(18'(wake), 18'h0);
		sample(3'h0, 1'b0);
		chk(18'(wake), 18'h1);
	endtask
	// Shake gating and front/back events in active mode, then shake muted in test mode
	task automatic t_tilt();
		wr(8'h07, 8'h00);
		wr(8'h06, 8'h81);
		wr(8'h07, 8'h01);
		wr(8'h08, 8'hA5);
		chk(18'(rcfg), 18'h5A);
		smp.shake = 3'h3;
		sample(3'h0, 1'b0);
		chk(18'(int_oe), 18'h0);
		smp.shake = 3'h4;
		sample(3'h0, 1'b0);
		chk(18'(int_oe), 18'h1);
		rdchk(8'h03, 8'h80);
		smp.shake = 3'h0;
		smp.bafro = 2'h1;
		sample(3'h0, 1'b0);
		chk(18'(int_oe), 18'h1);
		wr(8'h07, 8'h01);
		rdchk(8'h03, 8'h00);
		wr(8'h07, 8'h00);
		wr(8'h07, 8'h04);
		smp.shake = 3'h4;
		smp.bafro = 2'h2;
		sample(3'h0, 1'b0);
		chk(18'(int_oe), 18'h1);
		rdchk(8'h03, 8'h02);
	endtask
	task automatic give_verdict();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#1_500_000;
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b1;
		repeat (5) @(posedge clk_sys_in);
		#1;
		chk(18'({sda_o, int_oe}), 18'h0);
		for (int a = 4; a < 8; a++) begin
			rdchk(8'(a), 8'h00);
		end
		t_sleep(1'b0);
		t_sleep(1'b1);
		t_irq();
		t_test();
		host.half = 30;
		t_presc();
		host.half = 12;
		t_tilt();
		give_verdict();
	end
endmodule
